// [buck_voltage_map.sv]
// six-bit buck voltage code to millivolts
module buck_voltage_map (
    // code in
    input  wire logic [5:0]  code,
    // voltage out
    output logic      [11:0] millivolts
);
    always_comb begin
        if (code >= pmic_regs_pkg::TOP_FIRST_CODE) begin
            millivolts = pmic_regs_pkg::TOP_BASE_MV + pmic_regs_pkg::TOP_STEP_MV
                * 12'(code - pmic_regs_pkg::TOP_FIRST_CODE);
        end else if (code >= pmic_regs_pkg::MID_FIRST_CODE) begin
            millivolts = pmic_regs_pkg::MID_BASE_MV + pmic_regs_pkg::MID_STEP_MV
                * 12'(code - pmic_regs_pkg::MID_FIRST_CODE);
        end else begin
            millivolts = pmic_regs_pkg::FINE_BASE_MV + pmic_regs_pkg::FINE_STEP_MV * 12'(code);
        end
    end
endmodule

// [host_reg_master.sv]
// host model driving the byte register port
module host_reg_master (
    // clock
    input  wire logic       clock,
    // register port
    output logic      [7:0] regAddr,
    output logic      [7:0] regWrData,
    output logic            regWrEn,
    output logic            regRdEn,
    input  wire logic [7:0] regRdData
);
    timeunit 1ns;
    timeprecision 1ps;
    initial begin
        regAddr = 8'h00;
        regWrData = 8'h00;
        regWrEn = 1'b0;
        regRdEn = 1'b0;
    end
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(negedge clock);
        regAddr = a;
        regWrData = d;
        regWrEn = 1'b1;
        @(negedge clock);
        regWrEn = 1'b0;
        regWrData = ~d;
    endtask
    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        @(negedge clock);
        regAddr = a;
        regRdEn = 1'b1;
        @(negedge clock);
        regRdEn = 1'b0;
        d = regRdData;
    endtask
endmodule

// [pmic_regs_pkg.sv]
// constants for the supply control register slice
package pmic_regs_pkg;

    // ****************************************
    // register offsets
    // ****************************************
    localparam logic [7:0] SLEEP_LOCKOUT_CONTROL_OFS    = 8'h0e;
    localparam logic [7:0] CONVERTER_MODE_DISCHARGE_OFS = 8'h0f;
    localparam logic [7:0] BUCK_ONE_VOLTAGE_OFS         = 8'h10;
    localparam logic [7:0] BUCK_TWO_VOLTAGE_LOW_OFS     = 8'h11;
    localparam logic [7:0] BUCK_TWO_VOLTAGE_HIGH_OFS    = 8'h12;

    // ****************************************
    // field positions
    // ****************************************
    localparam int TIMER_ONE_SEC_BIT  = 7;
    localparam int TIMER_FIVE_SEC_BIT = 6;
    localparam int MEMORY_VALID_BIT   = 5;
    localparam int DEEP_SLEEP_BIT     = 4;
    localparam int B3_START_MASK_BIT  = 3;
    localparam int HYSTERESIS_BIT     = 2;
    localparam int THRESHOLD_LSB      = 0;
    localparam int FORCED_LSB         = 5;
    localparam int DISCHARGE_LSB      = 0;
    localparam int EXT_ADJ_BIT        = 7;
    localparam int CODE_LSB           = 0;

    // ****************************************
    // reset values
    // ****************************************
    localparam logic [4:0] SLEEP_CTRL_UPPER_RESET = 5'h01;
    localparam logic [2:0] SLEEP_CTRL_LOWER_RESET = 3'h5;
    localparam logic [7:0] MODE_DISCHARGE_RESET   = 8'h1f;
    localparam logic [5:0] BUCK_ONE_CODE_RESET    = 6'h3f;
    localparam logic [5:0] BUCK_TWO_LOW_RESET     = 6'h25;
    localparam logic [5:0] BUCK_TWO_HIGH_RESET    = 6'h3f;

    // ****************************************
    // lockout levels in millivolts
    // ****************************************
    localparam logic [12:0] THRESHOLD_00_MV = 13'd2800;
    localparam logic [12:0] THRESHOLD_01_MV = 13'd3000;
    localparam logic [12:0] THRESHOLD_10_MV = 13'd3100;
    localparam logic [12:0] THRESHOLD_11_MV = 13'd3250;
    localparam logic [12:0] HYSTERESIS_0_MV = 13'd400;
    localparam logic [12:0] HYSTERESIS_1_MV = 13'd500;

    // ****************************************
    // voltage code map
    // ****************************************
    localparam logic [11:0] FINE_BASE_MV   = 12'd725;
    localparam logic [11:0] FINE_STEP_MV   = 12'd25;
    localparam logic [5:0]  MID_FIRST_CODE = 6'h20;
    localparam logic [11:0] MID_BASE_MV    = 12'd1550;
    localparam logic [11:0] MID_STEP_MV    = 12'd50;
    localparam logic [5:0]  TOP_FIRST_CODE = 6'h3c;
    localparam logic [11:0] TOP_BASE_MV    = 12'd3000;
    localparam logic [11:0] TOP_STEP_MV    = 12'd100;

    // ****************************************
    // sequencing
    // ****************************************
    localparam logic [2:0] SEQ_OPT_000 = 3'h0;
    localparam logic [2:0] SEQ_OPT_001 = 3'h1;
    localparam logic [2:0] SEQ_OPT_010 = 3'h2;
    localparam logic [2:0] SEQ_OPT_011 = 3'h3;
    localparam logic [2:0] SEQ_OPT_100 = 3'h4;
    localparam logic [2:0] SEQ_OPT_101 = 3'h5;
    localparam logic [2:0] SEQ_OPT_110 = 3'h6;
    localparam logic [2:0] SEQ_OPT_111 = 3'h7;
    localparam logic [1:0] RANK_PIN    = 2'h3;
    localparam logic [1:0] RANK_LAST   = 2'h2;
    localparam int CLOCK_MHZ     = 250;
    localparam int STEP_TIME_US  = 1;
    localparam int STEP_CYCLES   = STEP_TIME_US * CLOCK_MHZ;
    localparam logic [7:0] STEP_LAST = 8'(STEP_CYCLES - 1);

    typedef enum logic [1:0] {
        RAILS_OFF  = 2'b00,
        RAILS_UP   = 2'b01,
        RAILS_ON   = 2'b10,
        RAILS_DOWN = 2'b11
    } rail_state_t;

endpackage

// [pmic_supply_control_regs.sv]
// supply control register slice with lockout and rail sequencing

module pmic_supply_control_regs (
    // clock and reset
    input  wire logic        clock,
    input  wire logic        rst,
    input  wire logic        clockEnable,
    // register port from the serial interface
    input  wire logic [7:0]  regAddr,
    input  wire logic [7:0]  regWrData,
    input  wire logic        regWrEn,
    input  wire logic        regRdEn,
    output logic      [7:0]  regRdData,
    // supply sensing and configuration
    input  wire logic [11:0] systemSupplyMv,
    input  wire logic        bandgapOk,
    input  wire logic [2:0]  buckSequenceOption,
    input  wire logic [2:0]  regulatorSequenceOption,
    input  wire logic        nvBuckOneExtAdj,
    input  wire logic        nvBuckTwoExtAdj,
    // pins and rail status
    input  wire logic        buckOneEnablePin,
    input  wire logic        buckTwoEnablePin,
    input  wire logic        buckThreeEnablePin,
    input  wire logic        buckTwoVoltageSelectPin,
    input  wire logic        regulatorTwoStarted,
    input  wire logic        regulatorTwoGood,
    input  wire logic        railsGood,
    // rail control
    output logic      [2:0]  buckEnable,
    output logic             externalRegulatorEnable,
    output logic             powerGoodOutput,
    output logic             lockoutActive,
    // converter settings
    output logic             timerOneSecEnable,
    output logic             timerFiveSecEnable,
    output logic      [2:0]  forcedFixedFrequency,
    output logic      [4:0]  dischargeEnable,
    output logic             buckOneExtAdj,
    output logic             buckTwoExtAdj,
    output logic      [5:0]  buckOneCode,
    output logic      [5:0]  buckTwoCode,
    output logic      [11:0] buckOneMv,
    output logic      [11:0] buckTwoMv
);

    // ****************************************
    // register storage
    // ****************************************
    logic [7:0] sleepCtrlQ;
    logic [7:0] modeDischargeQ;
    logic       b1ExtAdjQ;
    logic       b2ExtAdjQ;
    logic [5:0] b1CodeQ;
    logic [5:0] b2LowQ;
    logic [5:0] b2HighQ;
    logic       uvloQ;
    logic       wrSleep;
    logic       wrMode;
    logic       wrB1;
    logic       wrB2Low;
    logic       wrB2High;
    logic       deepSleep;
    logic [12:0] thresholdMv;
    logic [12:0] releaseMv;

    assign wrSleep  = regWrEn && regAddr == pmic_regs_pkg::SLEEP_LOCKOUT_CONTROL_OFS;
    assign wrMode   = regWrEn && regAddr == pmic_regs_pkg::CONVERTER_MODE_DISCHARGE_OFS;
    assign wrB1     = regWrEn && regAddr == pmic_regs_pkg::BUCK_ONE_VOLTAGE_OFS;
    assign wrB2Low  = regWrEn && regAddr == pmic_regs_pkg::BUCK_TWO_VOLTAGE_LOW_OFS;
    assign wrB2High = regWrEn && regAddr == pmic_regs_pkg::BUCK_TWO_VOLTAGE_HIGH_OFS;

    // ****************************************
    // lockout comparator
    // ****************************************
    always_comb begin
        case (sleepCtrlQ[pmic_regs_pkg::THRESHOLD_LSB +: 2])
            2'b00:   thresholdMv = pmic_regs_pkg::THRESHOLD_00_MV;
            2'b01:   thresholdMv = pmic_regs_pkg::THRESHOLD_01_MV;
            2'b10:   thresholdMv = pmic_regs_pkg::THRESHOLD_10_MV;
            default: thresholdMv = pmic_regs_pkg::THRESHOLD_11_MV;
        endcase
        releaseMv = thresholdMv + (sleepCtrlQ[pmic_regs_pkg::HYSTERESIS_BIT]
            ? pmic_regs_pkg::HYSTERESIS_1_MV : pmic_regs_pkg::HYSTERESIS_0_MV);
    end

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            uvloQ <= 1'b1;
        end else if (clockEnable) begin
            if ({1'b0, systemSupplyMv} < thresholdMv) begin
                uvloQ <= 1'b1;
            end else if ({1'b0, systemSupplyMv} >= releaseMv) begin
                uvloQ <= 1'b0;
            end
        end
    end

    // ****************************************
    // register writes and defaults
    // ****************************************
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            sleepCtrlQ <= {pmic_regs_pkg::SLEEP_CTRL_UPPER_RESET,
                           pmic_regs_pkg::SLEEP_CTRL_LOWER_RESET};
        end else if (clockEnable) begin
            if (uvloQ) begin
                sleepCtrlQ[7:3] <= pmic_regs_pkg::SLEEP_CTRL_UPPER_RESET;
            end else if (wrSleep) begin
                sleepCtrlQ[7:3] <= regWrData[7:3];
            end
            if (!bandgapOk) begin
                sleepCtrlQ[2:0] <= pmic_regs_pkg::SLEEP_CTRL_LOWER_RESET;
            end else if (wrSleep) begin
                sleepCtrlQ[2:0] <= regWrData[2:0];
            end
        end
    end

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            modeDischargeQ <= pmic_regs_pkg::MODE_DISCHARGE_RESET;
            b1CodeQ        <= pmic_regs_pkg::BUCK_ONE_CODE_RESET;
            b2LowQ         <= pmic_regs_pkg::BUCK_TWO_LOW_RESET;
            b2HighQ        <= pmic_regs_pkg::BUCK_TWO_HIGH_RESET;
            b1ExtAdjQ      <= 1'b0;
            b2ExtAdjQ      <= 1'b0;
        end else if (clockEnable) begin
            if (uvloQ) begin
                modeDischargeQ <= pmic_regs_pkg::MODE_DISCHARGE_RESET;
                b1CodeQ        <= pmic_regs_pkg::BUCK_ONE_CODE_RESET;
                b2LowQ         <= pmic_regs_pkg::BUCK_TWO_LOW_RESET;
                b2HighQ        <= pmic_regs_pkg::BUCK_TWO_HIGH_RESET;
                b1ExtAdjQ      <= nvBuckOneExtAdj;
                b2ExtAdjQ      <= nvBuckTwoExtAdj;
            end else begin
                if (wrMode) begin
                    modeDischargeQ <= regWrData;
                end
                if (wrB1) begin
                    b1ExtAdjQ <= regWrData[pmic_regs_pkg::EXT_ADJ_BIT];
                    b1CodeQ   <= regWrData[pmic_regs_pkg::CODE_LSB +: 6];
                end
                if (wrB2Low) begin
                    b2LowQ <= regWrData[pmic_regs_pkg::CODE_LSB +: 6];
                end
                if (wrB2High) begin
                    b2ExtAdjQ <= regWrData[pmic_regs_pkg::EXT_ADJ_BIT];
                    b2HighQ   <= regWrData[pmic_regs_pkg::CODE_LSB +: 6];
                end
            end
        end
    end

    // ****************************************
    // read port
    // ****************************************
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            regRdData <= 8'h00;
        end else if (clockEnable && regRdEn) begin
            case (regAddr)
                pmic_regs_pkg::SLEEP_LOCKOUT_CONTROL_OFS:    regRdData <= sleepCtrlQ;
                pmic_regs_pkg::CONVERTER_MODE_DISCHARGE_OFS: regRdData <= modeDischargeQ;
                pmic_regs_pkg::BUCK_ONE_VOLTAGE_OFS:         regRdData <= {b1ExtAdjQ, 1'b0, b1CodeQ};
                pmic_regs_pkg::BUCK_TWO_VOLTAGE_LOW_OFS:     regRdData <= {2'b00, b2LowQ};
                pmic_regs_pkg::BUCK_TWO_VOLTAGE_HIGH_OFS:    regRdData <= {b2ExtAdjQ, 1'b0, b2HighQ};
                default:                                     regRdData <= 8'h00;
            endcase
        end
    end

    // ****************************************
    // converter settings and voltage map
    // ****************************************
    logic [5:0]  selCode [2];

    assign selCode[0] = b1CodeQ;
    assign selCode[1] = buckTwoVoltageSelectPin ? b2HighQ : b2LowQ;

    for (genvar i = 0; i < 2; i++) begin : g_map
        logic [11:0] mapMv;
        logic [11:0] mvQ;
        buck_voltage_map u_map (
            .code       (selCode[i]),
            .millivolts (mapMv)
        );
        always_ff @(posedge clock or posedge rst) begin
            if (rst) begin
                mvQ <= 12'h000;
            end else if (clockEnable) begin
                mvQ <= mapMv;
            end
        end
    end

    assign buckOneMv = g_map[0].mvQ;
    assign buckTwoMv = g_map[1].mvQ;

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            timerOneSecEnable    <= 1'b0;
            timerFiveSecEnable   <= 1'b0;
            forcedFixedFrequency <= 3'h0;
            dischargeEnable      <= 5'h00;
            buckOneExtAdj        <= 1'b0;
            buckTwoExtAdj        <= 1'b0;
            buckOneCode          <= 6'h00;
            buckTwoCode          <= 6'h00;
            lockoutActive        <= 1'b1;
        end else if (clockEnable) begin
            timerOneSecEnable    <= sleepCtrlQ[pmic_regs_pkg::TIMER_ONE_SEC_BIT];
            timerFiveSecEnable   <= sleepCtrlQ[pmic_regs_pkg::TIMER_FIVE_SEC_BIT];
            forcedFixedFrequency <= modeDischargeQ[pmic_regs_pkg::FORCED_LSB +: 3];
            dischargeEnable      <= modeDischargeQ[pmic_regs_pkg::DISCHARGE_LSB +: 5];
            buckOneExtAdj        <= b1ExtAdjQ;
            buckTwoExtAdj        <= b2ExtAdjQ;
            buckOneCode          <= selCode[0];
            buckTwoCode          <= selCode[1];
            lockoutActive        <= uvloQ;
        end
    end

    // ****************************************
    // rail sequencing
    // ****************************************
    pmic_regs_pkg::rail_state_t stateQ;
    logic [1:0] stageQ;
    logic [7:0] stepCntQ;
    logic       stepTick;
    logic [1:0] rank [3];
    logic       maskOne;

    assign maskOne   = sleepCtrlQ[pmic_regs_pkg::B3_START_MASK_BIT];
    assign deepSleep = sleepCtrlQ[pmic_regs_pkg::DEEP_SLEEP_BIT]
        && buckSequenceOption == pmic_regs_pkg::SEQ_OPT_100
        && regulatorSequenceOption == pmic_regs_pkg::SEQ_OPT_111;
    assign stepTick  = stepCntQ == pmic_regs_pkg::STEP_LAST;

    // rank per buck: order of start, or pin-controlled
    always_comb begin
        rank[0] = pmic_regs_pkg::RANK_PIN;
        rank[1] = pmic_regs_pkg::RANK_PIN;
        rank[2] = pmic_regs_pkg::RANK_PIN;
        case (buckSequenceOption)
            pmic_regs_pkg::SEQ_OPT_000: rank[1] = 2'h0;
            pmic_regs_pkg::SEQ_OPT_001: begin
                rank[1] = 2'h0;
                rank[2] = 2'h0;
            end
            pmic_regs_pkg::SEQ_OPT_010: begin
                rank[0] = 2'h0;
                rank[1] = 2'h1;
                rank[2] = 2'h1;
            end
            pmic_regs_pkg::SEQ_OPT_011: begin
                rank[2] = 2'h0;
                rank[1] = 2'h1;
            end
            pmic_regs_pkg::SEQ_OPT_100: begin
                rank[0] = 2'h1;
                rank[1] = 2'h1;
                rank[2] = maskOne ? 2'h0 : pmic_regs_pkg::RANK_PIN;
            end
            pmic_regs_pkg::SEQ_OPT_110: begin
                rank[0] = 2'h0;
                rank[1] = 2'h1;
                rank[2] = 2'h2;
            end
            pmic_regs_pkg::SEQ_OPT_111: begin
                rank[0] = 2'h1;
                rank[1] = 2'h1;
            end
            default: rank[0] = pmic_regs_pkg::RANK_PIN;
        endcase
    end

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            stateQ   <= pmic_regs_pkg::RAILS_OFF;
            stageQ   <= 2'h0;
            stepCntQ <= 8'h00;
        end else if (clockEnable) begin
            stepCntQ <= (stepTick || stateQ == pmic_regs_pkg::RAILS_OFF
                || stateQ == pmic_regs_pkg::RAILS_ON) ? 8'h00 : stepCntQ + 8'h01;
            case (stateQ)
                pmic_regs_pkg::RAILS_OFF: if (!uvloQ) begin
                    stateQ <= pmic_regs_pkg::RAILS_UP;
                    stageQ <= 2'h0;
                end
                pmic_regs_pkg::RAILS_UP: if (uvloQ) begin
                    stateQ <= pmic_regs_pkg::RAILS_DOWN;
                end else if (stepTick) begin
                    if (stageQ == pmic_regs_pkg::RANK_LAST) begin
                        stateQ <= pmic_regs_pkg::RAILS_ON;
                    end else begin
                        stageQ <= stageQ + 2'h1;
                    end
                end
                pmic_regs_pkg::RAILS_ON: if (uvloQ) begin
                    stateQ <= pmic_regs_pkg::RAILS_DOWN;
                end
                pmic_regs_pkg::RAILS_DOWN: if (stepTick) begin
                    if (stageQ == 2'h0) begin
                        stateQ <= pmic_regs_pkg::RAILS_OFF;
                    end else begin
                        stageQ <= stageQ - 2'h1;
                    end
                end
                default: stateQ <= pmic_regs_pkg::RAILS_OFF;
            endcase
        end
    end

    // buck enables: sequenced ranks, pins, deep sleep
    logic [2:0] pinLevel;
    logic [2:0] enD;
    assign pinLevel = {buckThreeEnablePin, buckTwoEnablePin, buckOneEnablePin};

    always_comb begin
        for (int b = 0; b < 3; b++) begin
            if (stateQ == pmic_regs_pkg::RAILS_OFF) begin
                enD[b] = 1'b0;
            end else if (rank[b] == pmic_regs_pkg::RANK_PIN) begin
                enD[b] = pinLevel[b] && !uvloQ;
            end else if (b == 2 && buckSequenceOption == pmic_regs_pkg::SEQ_OPT_100) begin
                enD[b] = regulatorTwoStarted && !uvloQ;
            end else begin
                enD[b] = rank[b] <= stageQ;
            end
        end
        if (deepSleep) begin
            enD[0] = 1'b0;
            enD[2] = 1'b0;
        end
        // in RAILS_DOWN, a set memory-valid flag holds buck two up while regulator two is good
        if (stateQ == pmic_regs_pkg::RAILS_DOWN && sleepCtrlQ[pmic_regs_pkg::MEMORY_VALID_BIT]
            && regulatorTwoGood) begin
            enD[1] = 1'b1;
        end
    end

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            buckEnable              <= 3'h0;
            externalRegulatorEnable <= 1'b0;
            powerGoodOutput         <= 1'b0;
        end else if (clockEnable) begin
            buckEnable              <= enD;
            externalRegulatorEnable <= stateQ != pmic_regs_pkg::RAILS_OFF;
            powerGoodOutput         <= stateQ == pmic_regs_pkg::RAILS_ON
                && railsGood && !deepSleep;
        end
    end

    // ****************************************
    // checks
    // ****************************************
    default clocking cb @(posedge clock); endclocking
    default disable iff (rst);

    sequence lowSupply;
        clockEnable && {1'b0, systemSupplyMv} < thresholdMv;
    endsequence
    sequence sleepHeld;
        clockEnable && deepSleep ##1 clockEnable;
    endsequence

    lockout_entry_a: assert property (lowSupply |=> uvloQ)
        else $error("low supply did not enter lockout");
    valid_clear_a: assert property (clockEnable && uvloQ |=> !sleepCtrlQ[5])
        else $error("memory-valid flag survived lockout");
    valid_set_a: assert property (!sleepCtrlQ[5] && !(clockEnable && wrSleep && regWrData[5])
        |=> !sleepCtrlQ[5])
        else $error("memory-valid flag set without host write");
    sleep_power_good_output_a: assert property (sleepHeld |-> !powerGoodOutput && !buckEnable[0])
        else $error("deep sleep left power good or buck one on");
    defaults_load_a: assert property (clockEnable && uvloQ |=> modeDischargeQ == 8'h1f
        && b1CodeQ == 6'h3f && b2LowQ == 6'h25)
        else $error("lockout did not restore defaults");
    select_pin_a: assert property (clockEnable |=> buckTwoCode
        == ($past(buckTwoVoltageSelectPin) ? $past(b2HighQ) : $past(b2LowQ)))
        else $error("buck two code from wrong register");
    reserved_zero_a: assert property (clockEnable && regRdEn
        && regAddr == 8'h11 |=> regRdData[7:6] == 2'b00)
        else $error("reserved bits read nonzero");
    threshold_sel_a: assert property (sleepCtrlQ[1:0] == 2'b11 |-> thresholdMv == 13'd3250
        && releaseMv == thresholdMv + (sleepCtrlQ[2] ? 13'd500 : 13'd400))
        else $error("threshold or hysteresis wrong");
    map_top_a: assert property (clockEnable && selCode[0] == 6'h3f |=> buckOneMv == 12'd3300)
        else $error("top code not 3300 mV");
    forced_a: assert property (clockEnable |=> forcedFixedFrequency == $past(modeDischargeQ[7:5]))
        else $error("forced mode bits not followed");

endmodule

// [pmic_supply_control_regs_tb_top.sv]
// self-checking bench for the supply control register slice
module pmic_supply_control_regs_tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    logic        clock, rst, regWrEn, regRdEn, sel, lockoutActive, t1, t5, b1x, b2x, pg, ext;
    logic [4:0]  dis;
    logic [7:0]  crn [3] = '{8'h0d, 8'h15, 8'h05};
    logic [7:0]  regAddr, regWrData, regRdData, d;
    logic [11:0] systemSupplyMv, b1mv, b2mv;
    logic [2:0]  fff, bso, rso, pins, be;
    logic [5:0]  b1c, b2c;
    logic [7:0]  adr [5] = '{8'h0e, 8'h0f, 8'h10, 8'h11, 8'h12};
    logic [7:0]  mdl [5] = '{8'h0d, 8'h1f, 8'hbf, 8'h25, 8'h3f};
    int          errors = 0, nCompared = 0, j;
    host_reg_master host_reg_master_i (.clock, .regAddr, .regWrData, .regWrEn,
        .regRdEn, .regRdData);
    pmic_supply_control_regs pmic_supply_control_regs_i (.clock, .rst,
        .clockEnable(1'b1), .regAddr, .regWrData, .regWrEn, .regRdEn, .regRdData,
        .systemSupplyMv, .bandgapOk(1'b1), .buckSequenceOption(bso),
        .regulatorSequenceOption(rso), .nvBuckOneExtAdj(1'b1), .nvBuckTwoExtAdj(1'b0),
        .buckOneEnablePin(pins[0]), .buckTwoEnablePin(pins[1]),
        .buckThreeEnablePin(pins[2]), .buckTwoVoltageSelectPin(sel),
        .regulatorTwoStarted(!pins[2]), .regulatorTwoGood(pins[1]), .railsGood(pins[0]),
        .buckEnable(be), .externalRegulatorEnable(ext), .powerGoodOutput(pg), .lockoutActive,
        .timerOneSecEnable(t1), .timerFiveSecEnable(t5), .forcedFixedFrequency(fff),
        .dischargeEnable(dis), .buckOneExtAdj(b1x), .buckTwoExtAdj(b2x), .buckOneCode(b1c),
        .buckTwoCode(b2c), .buckOneMv(b1mv), .buckTwoMv(b2mv));
    function automatic logic [11:0] vmap(input logic [5:0] c);
        if (c < 6'h20) return 12'(725 + 25 * c);
        if (c < 6'h3c) return 12'(1550 + 50 * (c - 32));
        return 12'(3000 + 100 * (c - 60));
    endfunction
    function automatic logic [2:0] railsOn(input logic [2:0] o, input logic m, input logic ds);
        logic [2:0] r;
        case (o)
            3'h0: r = 3'b010 | pins;
            3'h1, 3'h3: r = 3'b110 | pins;
            3'h4: r = {m ? !pins[2] : pins[2], 2'b11};
            3'h5: r = pins;
            3'h7: r = 3'b011 | pins;
            default: r = 3'b111;
        endcase
        return ds ? (r & 3'b010) : r;
    endfunction
    task automatic railCheck(input string name);
        logic ds;
        ds = mdl[0][4] && bso == 3'h4 && rso == 3'h7;
        cmp(be, railsOn(bso, mdl[0][3], ds));
        cmp({pg, ext}, {pins[0] && !ds, 1'b1});
        $display("test %0s done", name);
    endtask
    task automatic cmp(input logic [11:0] g, input logic [11:0] e);
        nCompared++;
        if (g !== e) begin
            errors++;
            $display("ERROR t=%0t got=%0h exp=%0h", $time, g, e);
        end
    endtask
    task automatic chkAll(input string name);
        for (int k = 0; k < 5; k++) begin
            host_reg_master_i.rd(adr[k], d);
            cmp(d, mdl[k]);
        end
        host_reg_master_i.rd(8'h13, d);
        cmp(d, 8'h00);
        $display("test %0s done", name);
    endtask
    task automatic waitLock(input logic lv);
        for (int n = 0; n < 3000 && lockoutActive !== lv; n++) @(negedge clock);
        cmp(lockoutActive, lv);
    endtask
    task print_verdict;
        $display("compared %0d mismatches %0d", nCompared, errors);
        if (errors == 0 && nCompared > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask
    initial begin
        clock = 1'b0;
        forever #2 clock = ~clock;
    end
    initial begin
        #100us;
        errors++;
        print_verdict;
    end
    initial begin
        rst = 1'b1;
        sel = 1'b0;
        systemSupplyMv = 12'h000;
        void'($urandom(12612));
        {bso, rso, pins} = 9'($urandom);
        repeat (5) @(negedge clock);
        rst = 1'b0;
        systemSupplyMv = 12'hed8;
        waitLock(1'b0);
        host_reg_master_i.wr(8'h13, 8'hff);
        chkAll("defaults");
        for (int i = 0; i < 14; i++) begin
            j = (i == 0) ? 2 : int'($urandom % 5);
            d = (i == 0) ? 8'hff : 8'($urandom);
            host_reg_master_i.wr(adr[j], d);
            mdl[j] = d & ((j == 3) ? 8'h3f : (j > 1) ? 8'hbf : 8'hff);
            sel = 1'($urandom);
            repeat (3) @(negedge clock);
            cmp({fff, dis}, mdl[1]);
            cmp({t1, t5}, mdl[0][7:6]);
            cmp({b1x, b1c}, {mdl[2][7], mdl[2][5:0]});
            cmp(b2x, mdl[4][7]);
            cmp(b1mv, vmap(mdl[2][5:0]));
            cmp(b2c, mdl[sel ? 4 : 3][5:0]);
            cmp(b2mv, vmap(mdl[sel ? 4 : 3][5:0]));
        end
        chkAll("random");
        repeat (800) @(negedge clock);
        railCheck("rails on");
        {bso, rso} = 6'h27;
        foreach (crn[k]) begin
            host_reg_master_i.wr(8'h0e, crn[k]);
            mdl[0] = crn[k];
            repeat (3) @(negedge clock);
            railCheck("strap corner");
        end
        systemSupplyMv = 12'h3e8;
        waitLock(1'b1);
        host_reg_master_i.wr(8'h0f, 8'h00);
        mdl = '{{5'h01, mdl[0][2:0]}, 8'h1f, 8'hbf, 8'h25, 8'h3f};
        chkAll("lockout");
        repeat (800) @(negedge clock);
        cmp({be, pg, ext}, 5'h00);
        systemSupplyMv = 12'hed8;
        waitLock(1'b0);
        host_reg_master_i.wr(8'h0e, mdl[0]);
        print_verdict;
    end
endmodule
